// *** src/scb_bridge_dev.sv ***
// Scan chain bridge registers, both access variants, and shift engine
module scb_bridge_dev #(
    parameter logic [11:0] NEXT_CAP_OFFSET = 12'h000,
    parameter logic [15:0] CAP_IDENT = 16'h0a5a, // Arbitrary value
    parameter logic [3:0] CAP_REV = 4'h3, // Arbitrary value
    parameter logic [31:0] FEATURE_VERSION = 32'h0000_0001
) (
    input wire logic CLK, // System clock
    input wire logic RESETN, // Async reset, active low
    scb_link_if.dev LINK, // Host side access
    output logic SCAN_TCK, // Scan clock
    output logic SCAN_TMS, // Scan mode select
    output logic SCAN_TDI, // Scan data to chain
    input wire logic SCAN_TDO, // Scan data from chain
    output logic SCAN_ACTIVE // Shift in progress
);
    import scb_pkg::*;

    typedef struct packed {
        logic [31:0] shift_len;
        logic [31:0] tms;
        logic [31:0] tdi;
        logic [31:0] tdo;
        logic busy;
        logic done;
        logic [5:0] bit_cnt;
        logic [7:0] div_cnt;
        logic tck;
        logic tms_o;
        logic tdi_o;
        logic tdo_s1;
        logic tdo_s2;
        logic aw_rdy;
        logic w_rdy;
        logic ar_rdy;
        logic aw_got;
        logic w_got;
        logic [7:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic cfg_done;
        logic [31:0] cfg_rdata;
    } scb_dev_state_type;

    scb_dev_state_type s_r;
    scb_dev_state_type s_nxt;

    function automatic logic [31:0] status_word(scb_dev_state_type s);
        logic [31:0] w;
        w = RESET_WORD;
        w[STAT_DONE_BIT] = s.done;
        w[STAT_BUSY_BIT] = s.busy;
        return w;
    endfunction

    // Apply one masked register write; a start while busy is ignored
    function automatic scb_dev_state_type do_write(scb_dev_state_type s, scb_sel_type sel,
                                                   logic [31:0] d, logic [31:0] m);
        scb_dev_state_type n;
        n = s;
        case (sel)
            SEL_LEN: n.shift_len = (s.shift_len & ~m) | (d & m);
            SEL_TMS: n.tms = (s.tms & ~m) | (d & m);
            SEL_TDI: n.tdi = (s.tdi & ~m) | (d & m);
            SEL_CTRL: begin
                if (d[CTRL_START_BIT] && m[CTRL_START_BIT] && !s_r.busy) begin
                    n.busy = 1'b1;
                    n.done = 1'b0;
                    n.bit_cnt = '0;
                    n.div_cnt = '0;
                    n.tdo = RESET_WORD;
                    n.tms_o = s.tms[0];
                    n.tdi_o = s.tdi[0];
                end
            end
            default: n = s;
        endcase
        return n;
    endfunction

    always_comb begin
        logic [7:0] a;
        logic [31:0] m;
        logic [31:0] rd;
        logic hit;
        scb_sel_type sel;
        logic [5:0] eff_len;
        a = '0;
        m = '0;
        rd = '0;
        hit = 1'b0;
        sel = SEL_NONE;
        eff_len = '0;
        s_nxt = s_r;
        s_nxt.cfg_done = 1'b0;
        s_nxt.tdo_s1 = SCAN_TDO;
        s_nxt.tdo_s2 = s_r.tdo_s1;

        // Shift engine: TCK low drives bits, rising edge samples TDO
        eff_len = (s_r.shift_len > 32'(MAX_SHIFT_BITS)) ? MAX_SHIFT_BITS
                                                          : s_r.shift_len[5:0];
        if (s_r.busy) begin
            if (s_r.div_cnt == SCAN_DIV_LAST) begin
                s_nxt.div_cnt = '0;
                if (!s_r.tck) begin
                    if (s_r.bit_cnt == eff_len) begin
                        s_nxt.busy = 1'b0;
                        s_nxt.done = 1'b1;
                    end else begin
                        s_nxt.tck = 1'b1;
                        s_nxt.tdo[s_r.bit_cnt[4:0]] = s_r.tdo_s2;
                    end
                end else begin
                    s_nxt.tck = 1'b0;
                    s_nxt.bit_cnt = s_r.bit_cnt + 6'h01;
                    s_nxt.tms_o = s_r.tms[5'(s_r.bit_cnt[4:0] + 5'h01)];
                    s_nxt.tdi_o = s_r.tdi[5'(s_r.bit_cnt[4:0] + 5'h01)];
                end
            end else begin
                s_nxt.div_cnt = s_r.div_cnt + 8'h01;
            end
        end

        // AXI4-Lite write: address and data taken in either order
        if (s_r.aw_rdy && LINK.awvalid) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.aw_addr = LINK.awaddr;
        end
        if (s_r.w_rdy && LINK.wvalid) begin
            s_nxt.w_got = 1'b1;
            s_nxt.w_data = LINK.wdata;
            s_nxt.w_strb = LINK.wstrb;
        end
        if (s_r.bvalid && LINK.bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
            a = {s_r.aw_addr[7:2], 2'b00};
            m = {{8{s_r.w_strb[3]}}, {8{s_r.w_strb[2]}}, {8{s_r.w_strb[1]}},
                 {8{s_r.w_strb[0]}}};
            hit = 1'b1;
            case (a)
                MM_SHIFT_LEN: sel = SEL_LEN;
                MM_TMS: sel = SEL_TMS;
                MM_TDI: sel = SEL_TDI;
                MM_CONTROL: sel = SEL_CTRL;
                MM_TDO, MM_STATUS, MM_VERSION: sel = SEL_NONE;
                default: hit = 1'b0;
            endcase
            s_nxt = do_write(s_nxt, sel, s_r.w_data, m);
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = hit ? RESP_OKAY : RESP_DECERR;
        end

        // AXI4-Lite read
        if (s_r.rvalid && LINK.rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (s_r.ar_rdy && LINK.arvalid) begin
            a = {LINK.araddr[7:2], 2'b00};
            hit = 1'b1;
            case (a)
                MM_SHIFT_LEN: rd = s_r.shift_len;
                MM_TMS: rd = s_r.tms;
                MM_TDI: rd = s_r.tdi;
                MM_TDO: rd = s_r.tdo;
                MM_CONTROL: rd = RESET_WORD;
                MM_STATUS: rd = status_word(s_r);
                MM_VERSION: rd = FEATURE_VERSION;
                default: hit = 1'b0;
            endcase
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = rd;
            s_nxt.rresp = hit ? RESP_OKAY : RESP_DECERR;
        end

        // Configuration-space access, answered next cycle
        if (LINK.cfg_rd || LINK.cfg_wr) begin
            a = {LINK.cfg_addr[7:2], 2'b00};
            sel = SEL_NONE;
            case (a)
                CFG_CAP_HDR: rd = {NEXT_CAP_OFFSET, EXT_CAP_VER,
                                   EXT_CAP_ID};
                CFG_VND_HDR: rd = {CAP_STRUCT_LEN, CAP_REV,
                                   CAP_IDENT};
                CFG_VERSION: rd = FEATURE_VERSION;
                CFG_SHIFT_LEN: begin
                    rd = s_r.shift_len;
                    sel = SEL_LEN;
                end
                CFG_TMS: begin
                    rd = s_r.tms;
                    sel = SEL_TMS;
                end
                CFG_SCAN_DATA: begin
                    rd = s_r.tdo;
                    sel = SEL_TDI;
                end
                CFG_CONTROL: begin
                    rd = RESET_WORD;
                    sel = SEL_CTRL;
                end
                CFG_STATUS: rd = status_word(s_r);
                default: rd = RESET_WORD;
            endcase
            if (LINK.cfg_wr) begin
                s_nxt = do_write(s_nxt, sel, LINK.cfg_wdata, '1);
            end
            s_nxt.cfg_done = 1'b1;
            s_nxt.cfg_rdata = LINK.cfg_rd ? rd : RESET_WORD;
        end

        // Ready only while nothing is held for that channel
        s_nxt.aw_rdy = !s_nxt.aw_got && !s_nxt.bvalid;
        s_nxt.w_rdy = !s_nxt.w_got && !s_nxt.bvalid;
        s_nxt.ar_rdy = !s_nxt.rvalid;
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign LINK.awready = s_r.aw_rdy;
    assign LINK.wready = s_r.w_rdy;
    assign LINK.bvalid = s_r.bvalid;
    assign LINK.bresp = s_r.bresp;
    assign LINK.arready = s_r.ar_rdy;
    assign LINK.rvalid = s_r.rvalid;
    assign LINK.rdata = s_r.rdata;
    assign LINK.rresp = s_r.rresp;
    assign LINK.cfg_done = s_r.cfg_done;
    assign LINK.cfg_rdata = s_r.cfg_rdata;
    assign SCAN_TCK = s_r.tck;
    assign SCAN_TMS = s_r.tms_o;
    assign SCAN_TDI = s_r.tdi_o;
    assign SCAN_ACTIVE = s_r.busy;
endmodule

// *** src/scb_pkg.sv ***
// Shared constants and types of the scan chain bridge
package scb_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // Configuration-space map, byte offsets from the capability base
    localparam logic [7:0] CFG_CAP_HDR = 8'h00;
    localparam logic [7:0] CFG_VND_HDR = 8'h04;
    localparam logic [7:0] CFG_VERSION = 8'h08;
    localparam logic [7:0] CFG_SHIFT_LEN = 8'h0c;
    localparam logic [7:0] CFG_TMS = 8'h10;
    localparam logic [7:0] CFG_SCAN_DATA = 8'h14;
    localparam logic [7:0] CFG_CONTROL = 8'h18;
    localparam logic [7:0] CFG_STATUS = 8'h1c;
    // Memory-bus map, byte offsets from the assigned range
    localparam logic [7:0] MM_SHIFT_LEN = 8'h00;
    localparam logic [7:0] MM_TMS = 8'h04;
    localparam logic [7:0] MM_TDI = 8'h08;
    localparam logic [7:0] MM_TDO = 8'h0c;
    localparam logic [7:0] MM_CONTROL = 8'h10;
    localparam logic [7:0] MM_STATUS = 8'h14;
    localparam logic [7:0] MM_VERSION = 8'h18;
    // Header fields
    localparam logic [15:0] EXT_CAP_ID = 16'h000b;
    localparam logic [3:0] EXT_CAP_VER = 4'h1;
    localparam logic [11:0] CAP_STRUCT_LEN = 12'h020;
    // Control and status bit positions
    localparam int CTRL_START_BIT = 0;
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [5:0] MAX_SHIFT_BITS = 6'h20;
    // Scan clock timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCAN_HALF_NS = 40;
    localparam int SCAN_HALF_CYC = SCAN_HALF_NS / CLK_PERIOD_NS;
    localparam logic [7:0] SCAN_DIV_LAST = 8'(SCAN_HALF_CYC - 1);
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;
    // Register selector for writes
    typedef enum logic [2:0] {
        SEL_NONE = 3'b000,
        SEL_LEN = 3'b001,
        SEL_TMS = 3'b010,
        SEL_TDI = 3'b011,
        SEL_CTRL = 3'b100
    } scb_sel_type;
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_WRITE = 3'b001,
        H_BRESP = 3'b010,
        H_RADDR = 3'b011,
        H_RDATA = 3'b100,
        H_CFG = 3'b101
    } scb_host_state_type;
endpackage

// *** src/scb_link_if.sv ***
// Link between the host requester and the bridge registers
interface scb_link_if (
    input wire logic clk,
    input wire logic resetn
);
    import scb_pkg::*;
    logic [ADDR_W-1:0] awaddr;
    logic awvalid;
    logic awready;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready;
    logic [ADDR_W-1:0] araddr;
    logic arvalid;
    logic arready;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready;
    // Configuration-space access
    logic cfg_rd;
    logic cfg_wr;
    logic [ADDR_W-1:0] cfg_addr;
    logic [DATA_W-1:0] cfg_wdata;
    logic cfg_done;
    logic [DATA_W-1:0] cfg_rdata;
    modport dev (
        input awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready,
        input cfg_rd, cfg_wr, cfg_addr, cfg_wdata,
        output awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid,
        output cfg_done, cfg_rdata
    );
    modport host (
        output awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready,
        output cfg_rd, cfg_wr, cfg_addr, cfg_wdata,
        input awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid,
        input cfg_done, cfg_rdata
    );
endinterface

// *** src/scb_host_req.sv ***
// Host requester: turns user commands into config or AXI4-Lite accesses
module scb_host_req (
    input wire logic CLK, // System clock
    input wire logic RESETN, // Async reset, active low
    scb_link_if.host LINK, // Bridge side
    input wire logic CMD_VALID, // Command offered
    output logic CMD_READY, // Command taken when high with valid
    input wire logic CMD_CFG, // 1: config space, 0: memory bus
    input wire logic CMD_WRITE, // 1: write, 0: read
    input wire logic [scb_pkg::ADDR_W-1:0] CMD_ADDR, // Byte offset
    input wire logic [scb_pkg::DATA_W-1:0] CMD_WDATA, // Write data
    output logic RSP_VALID, // Answer pulse
    output logic [scb_pkg::DATA_W-1:0] RSP_DATA, // Read data
    output logic [1:0] RSP_RESP // Bus response code
);
    import scb_pkg::*;

    typedef struct packed {
        scb_host_state_type st;
        logic cmd_rdy;
        logic awvalid;
        logic wvalid;
        logic [7:0] addr;
        logic [31:0] wdata;
        logic bready;
        logic arvalid;
        logic rready;
        logic cfg_rd;
        logic cfg_wr;
        logic rsp_valid;
        logic [31:0] rsp_data;
        logic [1:0] rsp_resp;
    } scb_host_reg_type;

    scb_host_reg_type h_r;
    scb_host_reg_type h_nxt;

    always_comb begin
        h_nxt = h_r;
        h_nxt.rsp_valid = 1'b0;
        h_nxt.cfg_rd = 1'b0;
        h_nxt.cfg_wr = 1'b0;
        case (h_r.st)
            H_IDLE: begin
                h_nxt.cmd_rdy = 1'b1;
                if (h_r.cmd_rdy && CMD_VALID) begin
                    h_nxt.cmd_rdy = 1'b0;
                    h_nxt.addr = CMD_ADDR;
                    h_nxt.wdata = CMD_WDATA;
                    if (CMD_CFG) begin
                        h_nxt.cfg_rd = !CMD_WRITE;
                        h_nxt.cfg_wr = CMD_WRITE;
                        h_nxt.st = H_CFG;
                    end else if (CMD_WRITE) begin
                        h_nxt.awvalid = 1'b1;
                        h_nxt.wvalid = 1'b1;
                        h_nxt.st = H_WRITE;
                    end else begin
                        h_nxt.arvalid = 1'b1;
                        h_nxt.st = H_RADDR;
                    end
                end
            end
            H_WRITE: begin
                if (LINK.awready) begin
                    h_nxt.awvalid = 1'b0;
                end
                if (LINK.wready) begin
                    h_nxt.wvalid = 1'b0;
                end
                if (!h_nxt.awvalid && !h_nxt.wvalid) begin
                    h_nxt.bready = 1'b1;
                    h_nxt.st = H_BRESP;
                end
            end
            H_BRESP: begin
                if (LINK.bvalid) begin
                    h_nxt.bready = 1'b0;
                    h_nxt.rsp_valid = 1'b1;
                    h_nxt.rsp_data = '0;
                    h_nxt.rsp_resp = LINK.bresp;
                    h_nxt.st = H_IDLE;
                end
            end
            H_RADDR: begin
                if (LINK.arready) begin
                    h_nxt.arvalid = 1'b0;
                    h_nxt.rready = 1'b1;
                    h_nxt.st = H_RDATA;
                end
            end
            H_RDATA: begin
                if (LINK.rvalid) begin
                    h_nxt.rready = 1'b0;
                    h_nxt.rsp_valid = 1'b1;
                    h_nxt.rsp_data = LINK.rdata;
                    h_nxt.rsp_resp = LINK.rresp;
                    h_nxt.st = H_IDLE;
                end
            end
            H_CFG: begin
                if (LINK.cfg_done) begin
                    h_nxt.rsp_valid = 1'b1;
                    h_nxt.rsp_data = LINK.cfg_rdata;
                    h_nxt.rsp_resp = RESP_OKAY;
                    h_nxt.st = H_IDLE;
                end
            end
            default: h_nxt.st = H_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            h_r <= '0;
        end else begin
            h_r <= h_nxt;
        end
    end

    assign LINK.awaddr = h_r.addr;
    assign LINK.awvalid = h_r.awvalid;
    assign LINK.wdata = h_r.wdata;
    assign LINK.wstrb = 4'hf;
    assign LINK.wvalid = h_r.wvalid;
    assign LINK.bready = h_r.bready;
    assign LINK.araddr = h_r.addr;
    assign LINK.arvalid = h_r.arvalid;
    assign LINK.rready = h_r.rready;
    assign LINK.cfg_rd = h_r.cfg_rd;
    assign LINK.cfg_wr = h_r.cfg_wr;
    assign LINK.cfg_addr = h_r.addr;
    assign LINK.cfg_wdata = h_r.wdata;
    assign CMD_READY = h_r.cmd_rdy;
    assign RSP_VALID = h_r.rsp_valid;
    assign RSP_DATA = h_r.rsp_data;
    assign RSP_RESP = h_r.rsp_resp;
endmodule

// *** bench/scb_link_chk.sv ***
// Protocol and content checker for the scan chain bridge link
module scb_link_chk
    import scb_pkg::*;
#(
    parameter logic [11:0] NEXT_CAP_OFFSET = 12'h000,
    parameter logic [15:0] CAP_IDENT = 16'h0a5a,
    parameter logic [3:0] CAP_REV = 4'h3,
    parameter logic [31:0] FEATURE_VERSION = 32'h0000_0001
) (
    input wire logic clk, // Clock
    input wire logic resetn, // Reset, active low
    input wire logic awvalid, // Write address valid
    input wire logic awready, // Write address ready
    input wire logic wvalid, // Write data valid
    input wire logic wready, // Write data ready
    input wire logic bvalid, // Write response valid
    input wire logic bready, // Write response ready
    input wire logic arvalid, // Read address valid
    input wire logic arready, // Read address ready
    input wire logic [ADDR_W-1:0] araddr, // Read address
    input wire logic rvalid, // Read data valid
    input wire logic [DATA_W-1:0] rdata, // Read data
    input wire logic [1:0] rresp, // Read response
    input wire logic cfg_rd, // Config read pulse
    input wire logic cfg_wr, // Config write pulse
    input wire logic [ADDR_W-1:0] cfg_addr, // Config offset
    input wire logic cfg_done, // Config answer pulse
    input wire logic [DATA_W-1:0] cfg_rdata // Config read data
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    AST_CFG_DONE: assert property ((cfg_rd || cfg_wr) |=> cfg_done)
        else $error("config access not answered next cycle");
    AST_CAP_HDR: assert property ((cfg_rd && cfg_addr == 8'h00) |=>
        cfg_rdata == {NEXT_CAP_OFFSET, 4'h1, 16'h000b})
        else $error("capability header word wrong");
    AST_VND_HDR: assert property ((cfg_rd && cfg_addr == 8'h04) |=>
        cfg_rdata == {12'h020, CAP_REV, CAP_IDENT})
        else $error("vendor header word wrong");
    AST_CFG_VER: assert property ((cfg_rd && cfg_addr == 8'h08) |=>
        cfg_rdata == FEATURE_VERSION)
        else $error("config version word wrong");
    AST_B_LATENCY: assert property ((awvalid && awready && wvalid && wready) |->
        ##[1:2] bvalid)
        else $error("write response late");
    AST_B_DROP: assert property ((bvalid && bready) |=> !bvalid)
        else $error("write response repeated");
    AST_AW_BUSY: assert property ((awvalid && awready) |=> !awready && !wready)
        else $error("second write taken while one is open");
    AST_MM_VER: assert property ((arvalid && arready && araddr == 8'h18) |=>
        rvalid && rdata == FEATURE_VERSION && rresp == 2'b00)
        else $error("memory version read wrong");
    AST_DECERR: assert property ((arvalid && arready && araddr == 8'h1c) |=>
        rvalid && rresp == 2'b11)
        else $error("unmapped read not refused");
    AST_AR_LOW: assert property (rvalid |-> !arready)
        else $error("read address taken during read answer");
endmodule

// *** bench/tb_scb_bridge.sv ***
// Self-checking bench: host requester and bridge joined over the link
module tb_scb_bridge;
    timeunit 1ns;
    timeprecision 1ps;
    import scb_pkg::*;
    localparam logic [11:0] NXT = 12'h140;
    localparam logic [15:0] IDN = 16'h5c3e; // Arbitrary value
    localparam logic [3:0] REV = 4'h5; // Arbitrary value
    localparam logic [31:0] FVER = 32'h0001_0203;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_cfg = 1'b0;
    logic cmd_write = 1'b0;
    logic [7:0] cmd_addr = 8'h00;
    logic [31:0] cmd_wdata = 32'h0;
    logic tdo = 1'b0;
    logic cmd_ready, rsp_valid, tck, tms, tdi, active;
    logic [31:0] rsp_data, rd, tms_seen, tdi_seen;
    logic [31:0] tdo_pat = 32'h0;
    logic [1:0] rsp_resp, rr;
    int n_fail = 0;
    int n_checks = 0;
    int nbits = 0;

    always #5 clk = ~clk;

    scb_link_if link (.clk(clk), .resetn(resetn));
    scb_bridge_dev #(.NEXT_CAP_OFFSET(NXT), .CAP_IDENT(IDN), .CAP_REV(REV),
        .FEATURE_VERSION(FVER)) scb_bridge_dev_inst (.CLK(clk), .RESETN(resetn),
        .LINK(link), .SCAN_TCK(tck), .SCAN_TMS(tms), .SCAN_TDI(tdi), .SCAN_TDO(tdo),
        .SCAN_ACTIVE(active));
    scb_host_req scb_host_req_inst (.CLK(clk), .RESETN(resetn), .LINK(link),
        .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_CFG(cmd_cfg),
        .CMD_WRITE(cmd_write), .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata),
        .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .RSP_RESP(rsp_resp));
    scb_link_chk #(.NEXT_CAP_OFFSET(NXT), .CAP_IDENT(IDN), .CAP_REV(REV),
        .FEATURE_VERSION(FVER)) scb_link_chk_inst (.clk(link.clk), .resetn(link.resetn),
        .awvalid(link.awvalid), .awready(link.awready), .wvalid(link.wvalid),
        .wready(link.wready), .bvalid(link.bvalid), .bready(link.bready),
        .arvalid(link.arvalid), .arready(link.arready), .araddr(link.araddr),
        .rvalid(link.rvalid), .rdata(link.rdata), .rresp(link.rresp),
        .cfg_rd(link.cfg_rd), .cfg_wr(link.cfg_wr), .cfg_addr(link.cfg_addr),
        .cfg_done(link.cfg_done), .cfg_rdata(link.cfg_rdata));

    // Chain model: record what is shifted out, answer with the pattern
    always @(posedge tck) begin
        tms_seen[nbits] <= tms;
        tdi_seen[nbits] <= tdi;
        nbits <= nbits + 1;
    end
    always @(posedge clk) begin
        tdo <= tdo_pat[nbits[4:0]];
    end

    task automatic end_sim();
        if (n_fail == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic acc(input logic cfg, input logic wr, input logic [7:0] a,
        input logic [31:0] d, input logic [1:0] er);
        int i;
        @(posedge clk);
        cmd_cfg <= cfg;
        cmd_write <= wr;
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_valid <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (cmd_ready !== 1'b1 && i < 50);
        if (cmd_ready !== 1'b1) begin
            n_fail++;
            end_sim();
        end
        cmd_valid <= 1'b0;
        i = 0;
        do begin
            @(negedge clk);
            i++;
        end while (rsp_valid !== 1'b1 && i < 200);
        // A lost answer would hang every later step, so stop here
        if (rsp_valid !== 1'b1) begin
            n_fail++;
            end_sim();
        end
        rd = rsp_data;
        rr = rsp_resp;
        chk("resp", {30'h0, er}, {30'h0, rr});
    endtask

    task automatic rdc(input logic cfg, input logic [7:0] a, input logic [31:0] e,
        input string nm);
        acc(cfg, 1'b0, a, 32'h0, RESP_OKAY);
        chk(nm, e, rd);
    endtask

    task automatic t_headers();
        rdc(1'b1, 8'h00, {NXT, 4'h1, 16'h000b}, "cap_hdr");
        rdc(1'b1, 8'h04, {12'h020, REV, IDN}, "vnd_hdr");
        rdc(1'b1, 8'h08, FVER, "cfg_ver");
        rdc(1'b0, 8'h18, FVER, "mm_ver");
        acc(1'b1, 1'b1, 8'h00, 32'hffff_ffff, RESP_OKAY);
        rdc(1'b1, 8'h00, {NXT, 4'h1, 16'h000b}, "cap_hdr_ro");
        acc(1'b0, 1'b1, 8'h18, 32'hffff_ffff, RESP_OKAY);
        rdc(1'b0, 8'h18, FVER, "mm_ver_ro");
    endtask

    task automatic t_regs();
        acc(1'b1, 1'b1, 8'h0c, 32'h0000_0011, RESP_OKAY);
        rdc(1'b0, 8'h00, 32'h0000_0011, "len_shared");
        acc(1'b0, 1'b1, 8'h04, 32'ha5c3_0f96, RESP_OKAY);
        rdc(1'b1, 8'h10, 32'ha5c3_0f96, "tms_shared");
    endtask

    task automatic t_decerr();
        acc(1'b0, 1'b0, 8'h1c, 32'h0, RESP_DECERR);
        chk("bad_rd", 32'h0, rd);
        acc(1'b0, 1'b1, 8'h20, 32'h0000_0005, RESP_DECERR);
        rdc(1'b0, 8'h00, 32'h0000_0011, "len_kept");
    endtask

    task automatic t_shift(input logic cfg, input logic [31:0] len, input logic [31:0] tv,
        input logic [31:0] dv, input logic [31:0] ov);
        int i;
        logic [31:0] m;
        m = (len == 32) ? 32'hffff_ffff : (32'h1 << len) - 32'h1;
        tdo_pat = ov;
        acc(cfg, 1'b1, cfg ? CFG_TMS : MM_TMS, tv, RESP_OKAY);
        acc(cfg, 1'b1, cfg ? CFG_SCAN_DATA : MM_TDI, dv, RESP_OKAY);
        acc(cfg, 1'b1, cfg ? CFG_SHIFT_LEN : MM_SHIFT_LEN, len, RESP_OKAY);
        nbits = 0;
        acc(cfg, 1'b1, cfg ? CFG_CONTROL : MM_CONTROL, 32'h1, RESP_OKAY);
        for (i = 0; i < 100; i++) begin
            acc(cfg, 1'b0, cfg ? CFG_STATUS : MM_STATUS, 32'h0, RESP_OKAY);
            if (i == 0 && len > 0) begin
                chk("busy", 32'h2, rd & 32'h3);
                chk("active", 32'h1, {31'h0, active});
            end
            if (rd[0] === 1'b1) begin
                break;
            end
        end
        chk("done", 32'h1, rd & 32'h3);
        chk("bits", len, nbits);
        chk("tms_bits", tv & m, tms_seen & m);
        chk("tdi_bits", dv & m, tdi_seen & m);
        acc(cfg, 1'b0, cfg ? CFG_SCAN_DATA : MM_TDO, 32'h0, RESP_OKAY);
        chk("tdo_word", ov & m, rd & m);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        t_headers();
        t_regs();
        t_decerr();
        t_shift(1'b0, 32'd8, 32'h0000_00b4, 32'h0000_0069, 32'h0000_00c5);
        t_shift(1'b1, 32'd32, 32'h8000_0001, 32'h96e1_3c5a, 32'h3c5a_96e1);
        t_shift(1'b0, 32'd0, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
        end_sim();
    end
endmodule
